// ===== pcw_pkg.sv
// Shared constants and carriers for the positioner status and command word logic.
// Assumes one 20 MHz clock and positions held as signed 32-bit increments.
package pcw_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;

  // Status word bit positions
  localparam int unsigned ST_AT_TARGET  = 15;
  localparam int unsigned ST_RUNNING    = 14;
  localparam int unsigned ST_SUPPLY_OK  = 13;
  localparam int unsigned ST_READY      = 12;
  localparam int unsigned ST_HW_ERR     = 11;
  localparam int unsigned ST_ABORTED    = 10;
  localparam int unsigned ST_JOG_DOWN   = 9;
  localparam int unsigned ST_JOG_UP     = 8;
  localparam int unsigned ST_OVERTEMP   = 7;
  localparam int unsigned ST_DRAG_ERR   = 6;
  localparam int unsigned ST_INVALID    = 5;
  localparam int unsigned ST_POS_ERR    = 4;
  localparam int unsigned ST_MAN_ROT    = 3;
  localparam int unsigned ST_NO_SUPPLY  = 2;
  localparam int unsigned ST_LIM_UP     = 1;
  localparam int unsigned ST_LIM_DOWN   = 0;

  // Command word bit positions
  localparam int unsigned CMD_CONFIRM   = 8;
  localparam int unsigned CMD_RELEASE   = 7;
  localparam int unsigned CMD_MAN_REL   = 6;
  localparam int unsigned CMD_NO_LOOP   = 5;
  localparam int unsigned CMD_SET_REFV  = 4;
  localparam int unsigned CMD_SET_ZERO  = 3;
  localparam int unsigned CMD_ACCEPT    = 2;
  localparam int unsigned CMD_MAN_DOWN  = 1;
  localparam int unsigned CMD_MAN_UP    = 0;
  localparam logic [15:0] CMD_USED_MASK = 16'h01ff;

  localparam logic [15:0] STATUS_RST    = 16'h0000;

  // Motor supply floor in 0.1 V units
  localparam logic [15:0] LOW_SUPPLY_DV = 16'h00aa;

  // Jog pause unit: cycles per millisecond
  localparam int unsigned MS_NS         = 1_000_000;
  localparam int unsigned CLK_NS        = 1_000_000_000 / CLK_HZ;
  localparam int unsigned CYC_PER_MS    = MS_NS / CLK_NS;

  typedef struct packed {
    logic [15:0] min_supply_dv;  // Minimum motor supply, 0.1 V
    logic [15:0] temp_limit;     // Degrees C
    logic [15:0] pos_window;     // Increments
    logic [15:0] drag_limit;     // Increments
    logic [15:0] jog_pause_ms;   // 0 means single jog steps only
    logic [15:0] jog_step;       // Increments per jog
    logic        loop_enable;    // Reference loop configured
    logic        jog_param_en;   // Jog keys released by parameter
    logic        fw_new;         // Newer firmware behaviour
    logic signed [31:0] range_hi;
    logic signed [31:0] range_lo;
  } pcw_cfg_t;

  typedef struct packed {
    logic        int_err;        // Internal error detected
    logic        bad_value;      // Out of range target or parameter
    logic [15:0] supply_dv;      // Motor supply, 0.1 V
    logic [15:0] temp_c;         // Device temperature
    logic signed [31:0] act_pos; // Encoder position
  } pcw_sense_t;

  typedef struct packed {
    logic        run;            // Motor enabled
    logic        dir_up;         // Direction of motion
    logic        fast;           // Manual speed instead of increments
    logic        use_loop;       // Approach with reference loop
    logic signed [31:0] goal;    // Commanded position
  } pcw_drive_t;

  typedef enum logic [3:0] {
    PCW_IDLE  = 4'b0001,
    PCW_POS   = 4'b0010,
    PCW_STEP  = 4'b0100,
    PCW_MAN   = 4'b1000
  } pcw_state_t;

endpackage

// ===== pcw_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module pcw_sync
  import pcw_pkg::*;
#(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // pcw_sync
`default_nettype wire

// ===== pcw_errmem.sv
// Error memory: captures the error status on confirmation and hands a copy to
// non-volatile storage. Assumes the storage accepts a one-cycle save pulse.
`timescale 1ns/1ps
`default_nettype none
module pcw_errmem
  import pcw_pkg::*;
#(
  parameter int unsigned DEPTH = 8
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        capture,
  input  wire logic [15:0] err_status,
  input  wire logic        auto_save,
  input  wire logic        save_req,
  output logic             nv_save,
  output logic [15:0]      last_err
);
  logic [15:0]              mem_q [DEPTH];
  logic [$clog2(DEPTH)-1:0] wr_q;
  logic                     save_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q   <= '0;
      save_q <= 1'b0;
    end else begin
      save_q <= (capture && auto_save) || save_req;
      if (capture) begin
        mem_q[wr_q] <= err_status;
        wr_q        <= wr_q + 1'b1;
      end
    end
  end

  assign nv_save  = save_q;
  assign last_err = mem_q[wr_q - 1'b1];
endmodule // pcw_errmem
`default_nettype wire

// ===== pcw_core.sv
// Status and command word logic of a positioning drive.
// Assumes the command word and target come from the cyclic exchange on clk,
// and the jog keys arrive on pins asynchronous to clk.
// Behaviour
// - At-target flag within positioning window
// - Running flag during positioning run
// - Supply-ok flag gates run start
// - Ready flag; pending error blocks start
// - Internal error stops; release drop clears
// - Aborted flag on release drop or error
// - Jog key pins mirrored in status
// - Overtemp flag, cleared by confirmation
// - Drag error flag, run continues
// - Invalid value flag
// - Positioning error after run, cleared next
// - Manual rotation after completed run
// - Low supply flag, cleared on confirm fall
// - Range limit flags block outward jog start and manual speed
// - Confirm fall moves errors to memory
// - Save error memory automatically or explicitly
// - Motion only while release set
// - Manual release lets jog keys drive
// - No-loop bit suppresses reference loop
// - Reference value accepted when alone
// - Zero reference set when alone
// - Accept bit starts positioning run
// - Manual run: step, pause, continue
`timescale 1ns/1ps
`default_nettype none
module pcw_core
  import pcw_pkg::*;
#(
  parameter int unsigned ERR_DEPTH = 8,
  parameter int unsigned MS_CYCLES = CYC_PER_MS
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] drive_command_word,
  input  wire logic signed [31:0] target_pos,
  input  wire logic        save_cmd,
  input  wire logic        jog_down_pin,
  input  wire logic        jog_up_pin,
  input  wire pcw_cfg_t    cfg,
  input  wire pcw_sense_t  sense,
  output logic [15:0]      drive_status_word,
  output pcw_drive_t       drive,
  output logic signed [31:0] ref_offset,
  output logic             nv_save,
  output logic [15:0]      last_err
);
  // Jog pins pass two flops first
  logic [1:0] jog_s;
  pcw_sync #(.WIDTH(2)) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({jog_down_pin, jog_up_pin}),
    .sync_out (jog_s)
  );

  wire [15:0] cmd = drive_command_word & CMD_USED_MASK;

  logic [15:0] cmd_q;
  logic [15:0] flags_q;
  pcw_state_t  state_q;
  logic signed [31:0] ref_q;
  logic signed [31:0] goal_q;
  logic        done_q;
  logic [15:0] pause_q;
  logic [31:0] ms_cnt_q;

  wire confirm_fall = cmd_q[CMD_CONFIRM] && !cmd[CMD_CONFIRM];
  wire release_fall = cmd_q[CMD_RELEASE] && !cmd[CMD_RELEASE];
  wire release_on   = cmd[CMD_RELEASE];
  wire accept       = cmd[CMD_ACCEPT];

  // Position in user coordinates relative to the zero reference
  wire signed [31:0] pos    = sense.act_pos - ref_q;
  wire signed [31:0] diff   = pos - target_pos;
  wire [31:0] adiff         = diff[31] ? 32'(-diff) : 32'(diff);
  wire signed [31:0] lag    = pos - goal_q;
  wire [31:0] alag          = lag[31] ? 32'(-lag) : 32'(lag);
  wire in_window            = adiff <= {16'h0000, cfg.pos_window};

  wire supply_ok  = sense.supply_dv > cfg.min_supply_dv;
  wire supply_low = sense.supply_dv < LOW_SUPPLY_DV;
  wire hot        = sense.temp_c > cfg.temp_limit;
  wire over_hi    = pos > cfg.range_hi;
  wire under_lo   = pos < cfg.range_lo;

  // Any latched fault that stops new runs
  wire err_active = flags_q[ST_HW_ERR] | flags_q[ST_OVERTEMP] | flags_q[ST_NO_SUPPLY];
  // Ready when supplies, temperature and target are fine
  wire ready      = supply_ok && !hot && !flags_q[ST_OVERTEMP] && !sense.bad_value;
  wire may_start  = release_on && ready && !err_active;

  wire set_refv   = cmd == (16'h0001 << CMD_SET_REFV);
  wire set_zero   = cmd == (16'h0001 << CMD_SET_ZERO);

  // Jog source: command bits or released keys
  wire jog_en     = (cmd[CMD_MAN_REL] || cfg.jog_param_en) && !accept;
  wire man_up     = !accept && (cmd[CMD_MAN_UP] || (jog_en && jog_s[0]));
  wire man_down   = !accept && (cmd[CMD_MAN_DOWN] || (jog_en && jog_s[1]));
  wire man_any    = man_up ^ man_down;

  wire up_blocked   = over_hi;
  wire down_blocked = under_lo;

  wire run_stop   = !release_on || flags_q[ST_HW_ERR] || sense.int_err;
  wire ms_tick    = ms_cnt_q == 32'(MS_CYCLES - 1);
  wire running    = state_q != PCW_IDLE;

  // Millisecond divider for the jog pause
  always_ff @(posedge clk) begin
    if (!rst_n || state_q != PCW_STEP || ms_tick) begin
      ms_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_cnt_q + 32'd1;
    end
  end

  // Run sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= PCW_IDLE;
      goal_q  <= '0;
      pause_q <= '0;
      done_q  <= 1'b0;
    end else begin
      case (state_q)
        PCW_IDLE: begin
          if (accept && may_start && !set_refv && !set_zero) begin
            state_q <= PCW_POS;
            goal_q  <= target_pos;
            done_q  <= 1'b0;
          // Manual run begins with one jog step of jog_step increments
          end else if (man_any && may_start &&
                       !(man_up && up_blocked) && !(man_down && down_blocked)) begin
            state_q <= PCW_STEP;
            goal_q  <= man_up ? pos + 32'(cfg.jog_step) : pos - 32'(cfg.jog_step);
            pause_q <= '0;
            done_q  <= 1'b0;
          end
        end
        PCW_POS: begin
          if (run_stop) begin
            state_q <= PCW_IDLE;
          end else if (in_window) begin
            state_q <= PCW_IDLE;
            done_q  <= 1'b1;
          end else begin
            goal_q <= target_pos;
          end
        end
        PCW_STEP: begin
          // Pause then continue at manual speed; zero pause steps only
          if (run_stop || !man_any) begin
            state_q <= PCW_IDLE;
          end else if (ms_tick) begin
            pause_q <= pause_q + 16'h0001;
            if (cfg.jog_pause_ms != 16'h0000 && pause_q + 16'h0001 >= cfg.jog_pause_ms) begin
              state_q <= PCW_MAN;
            end
          end
        end
        PCW_MAN: begin
          if (run_stop || !man_any || (man_up && up_blocked) || (man_down && down_blocked)) begin
            state_q <= PCW_IDLE;
          end
        end
        default: state_q <= PCW_IDLE;
      endcase
    end
  end

  // Reference handling and command history
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_q <= '0;
      cmd_q <= '0;
    end else begin
      cmd_q <= cmd;
      // New reference value on an isolated bit-4 rise
      if (set_refv && !cmd_q[CMD_SET_REFV]) begin
        ref_q <= sense.act_pos - target_pos;
      // Zero here, or the target value on newer firmware
      end else if (set_zero && !cmd_q[CMD_SET_ZERO] && !running) begin
        ref_q <= cfg.fw_new ? sense.act_pos - target_pos : sense.act_pos;
      end
    end
  end

  // Status flags; sets win over clears
  logic [15:0] flags_d;
  always_comb begin
    flags_d = flags_q;
    flags_d[ST_AT_TARGET] = in_window;
    flags_d[ST_RUNNING]   = running;
    flags_d[ST_SUPPLY_OK] = supply_ok;
    flags_d[ST_READY]     = ready;
    flags_d[ST_JOG_DOWN]  = jog_s[1];
    flags_d[ST_JOG_UP]    = jog_s[0];
    flags_d[ST_DRAG_ERR]  = running && alag > {16'h0000, cfg.drag_limit};
    flags_d[ST_INVALID]   = sense.bad_value;
    // Range limits clear once back inside
    flags_d[ST_LIM_UP]    = over_hi;
    flags_d[ST_LIM_DOWN]  = under_lo;
    // Cleared by release drop or confirm fall
    if (release_fall || confirm_fall) flags_d[ST_HW_ERR] = 1'b0;
    if (sense.int_err) flags_d[ST_HW_ERR] = 1'b1;
    // Overtemp cleared only when cool and confirmed
    if (confirm_fall && !hot) flags_d[ST_OVERTEMP] = 1'b0;
    if (hot) flags_d[ST_OVERTEMP] = 1'b1;
    // Low supply cleared on confirm fall
    if (confirm_fall) flags_d[ST_NO_SUPPLY] = 1'b0;
    if (supply_low) flags_d[ST_NO_SUPPLY] = 1'b1;
    if (state_q == PCW_IDLE && (accept || man_any) && may_start) flags_d[ST_ABORTED] = 1'b0;
    if (running && run_stop) flags_d[ST_ABORTED] = 1'b1;
    // Positioning error cleared during next positioning run
    if (state_q == PCW_POS) flags_d[ST_POS_ERR] = 1'b0;
    if (state_q == PCW_POS && run_stop && !in_window) flags_d[ST_POS_ERR] = 1'b1;
    // Pushed away after a completed run
    if (running) flags_d[ST_MAN_ROT] = 1'b0;
    // Judged against the finished goal, so a new target alone does not raise it
    if (!running && done_q && alag > {16'h0000, cfg.pos_window}) flags_d[ST_MAN_ROT] = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_q <= STATUS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  pcw_errmem #(.DEPTH(ERR_DEPTH)) u_errmem (
    .clk        (clk),
    .rst_n      (rst_n),
    .capture    (confirm_fall || (release_fall && flags_q[ST_HW_ERR])),
    .err_status (flags_q),
    .auto_save  (cfg.fw_new),
    .save_req   (save_cmd),
    .nv_save    (nv_save),
    .last_err   (last_err)
  );

  assign drive_status_word = flags_q;
  assign ref_offset        = ref_q;
  assign drive.run         = running && !run_stop;
  assign drive.dir_up      = goal_q > pos;
  assign drive.fast        = state_q == PCW_MAN;
  assign drive.use_loop    = cfg.loop_enable && !cmd[CMD_NO_LOOP];
  assign drive.goal        = goal_q;

  a_release_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !release_on |-> ##1 !drive.run) else $error("motor enabled without release");

  a_err_stops: assert property (@(posedge clk) disable iff (!rst_n)
    sense.int_err |=> flags_q[ST_HW_ERR] && !drive.run) else $error("error did not stop");

  a_run_flag: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> drive_status_word[ST_RUNNING] == $past(state_q != PCW_IDLE))
    else $error("running flag wrong");

  // Low supply clear only on confirm fall
  a_low_supply: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(flags_q[ST_NO_SUPPLY]) |-> $past(confirm_fall)) else $error("supply flag cleared");

  // Start only with release and no error
  a_start_gate: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(running) |-> $past(release_on && !err_active && supply_ok)) else $error("bad start");

  a_jog_mirror: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 drive_status_word[ST_JOG_UP] == $past(jog_s[0]) &&
        drive_status_word[ST_JOG_DOWN] == $past(jog_s[1])) else $error("jog mirror wrong");

  a_abort_flag: assert property (@(posedge clk) disable iff (!rst_n)
    running && !release_on |=> flags_q[ST_ABORTED]) else $error("abort not flagged");

  // Upward manual-speed run stopped at upper limit
  a_limit_block: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == PCW_MAN && man_up && up_blocked |=> state_q == PCW_IDLE) else $error("limit");

  // A cut run: stop request while running, then idle with the abort flag up
  sequence s_run_cut;
    running && run_stop;
  endsequence

  sequence s_run_idle_flagged;
    !running && !drive.run && flags_q[ST_ABORTED];
  endsequence

  a_stop_done: assert property (@(posedge clk) disable iff (!rst_n)
    s_run_cut |=> s_run_idle_flagged) else $error("run not stopped");

  // Drag error never ends a positioning run
  a_drag_runs: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == PCW_POS && !run_stop && !in_window |=> state_q == PCW_POS)
    else $error("run interrupted");

  // No start while hot or flagged hot
  a_hot_gate: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(running) |-> $past(!hot && !flags_q[ST_OVERTEMP])) else $error("start while hot");

  // Overtemp clears only when cool and confirmed
  a_hot_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(flags_q[ST_OVERTEMP]) |-> $past(confirm_fall && !hot)) else $error("overtemp cleared");

  // Jog step still pausing: no millisecond tick this cycle
  sequence s_step_waiting;
    state_q == PCW_STEP && !ms_tick;
  endsequence

  // Manual speed only after the pause
  a_step_pause: assert property (@(posedge clk) disable iff (!rst_n)
    s_step_waiting |=> state_q != PCW_MAN) else $error("pause skipped");

  // Reference moves only on a lone command
  a_ref_alone: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(ref_q) |-> $past(set_refv || set_zero)) else $error("reference moved");

endmodule // pcw_core
`default_nettype wire

// ===== pcw_ctl_model.sv
// Control unit model: issues the command word and target on the cyclic exchange.
// Assumes the bench calls its tasks; every change lands just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module pcw_ctl_model
  import pcw_pkg::*;
(
  input  wire logic               clk,
  output var  logic [15:0]        cmd,
  output var  logic signed [31:0] tgt
);
  initial begin
    cmd = 16'h0000;
    tgt = 32'sh00000000;
  end

  task automatic put(input logic [15:0] c, input logic signed [31:0] t);
    @(posedge clk);
    cmd <= c;
    tgt <= t;
  endtask

  // value and bit together, bit held one exchange
  task automatic pulse(input logic [15:0] c, input logic signed [31:0] t);
    put(c, t);
    put(16'h0000, t);
  endtask
endmodule // pcw_ctl_model
`default_nettype wire

// ===== pcw_core_bench.sv
// Self-checking bench for the status and command word logic.
// Assumes the control unit model drives the command word; bench drives pins and sensors.
`timescale 1ns/1ps
`default_nettype none
module pcw_core_bench
  import pcw_pkg::*;
;
  logic               clk;
  logic               rst_n;
  logic               save_cmd;
  logic               jog_down_pin;
  logic               jog_up_pin;
  pcw_cfg_t           cfg;
  pcw_sense_t         sense;
  logic [15:0]        cmd;
  logic signed [31:0] tgt;
  logic [15:0]        status;
  pcw_drive_t         drive;
  logic signed [31:0] ref_offset;
  logic               nv_save;
  logic [15:0]        last_err;
  int                 n_errors;
  int                 n_tests;

  pcw_ctl_model ctl (.clk(clk), .cmd(cmd), .tgt(tgt));

  // Short pause unit keeps jog timing within a few cycles
  pcw_core #(.MS_CYCLES(4)) DUT (
    .clk(clk), .rst_n(rst_n), .drive_command_word(cmd), .target_pos(tgt),
    .save_cmd(save_cmd), .jog_down_pin(jog_down_pin), .jog_up_pin(jog_up_pin),
    .cfg(cfg), .sense(sense), .drive_status_word(status), .drive(drive),
    .ref_offset(ref_offset), .nv_save(nv_save), .last_err(last_err)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic final_report;
    if (n_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic obs(input int idx);
    if (idx < 16) return status[idx];
    if (idx == 16) return drive.run;
    if (idx == 17) return nv_save;
    if (idx == 18) return drive.use_loop;
    if (idx == 19) return drive.dir_up;
    return drive.fast;
  endfunction

  // Bounded wait for a flag, then compare it at a settled point
  task automatic expect_obs(input string nm, input int idx, input logic v, input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge clk);
      if (obs(idx) === v) break;
    end
    check(nm, obs(idx), v);
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic confirm_fall;
    ctl.put(16'h0180, tgt);
    ctl.put(16'h0080, tgt);
  endtask

  task automatic t_run;
    ctl.put(16'h0084, 32'sh000003e8);
    expect_obs("run start", 16, 1'b1, 4);
    expect_obs("running", 14, 1'b1, 4);
    check("goal", drive.goal, 32'h000003e8);
    check("drag err", obs(6), 1'b1);
    @(posedge clk) sense.act_pos <= 32'sh000003eb;
    expect_obs("at target", 15, 1'b1, 8);
    expect_obs("run ends", 14, 1'b0, 4);
    @(posedge clk) sense.act_pos <= 32'sh000003fc;
    expect_obs("pushed away", 3, 1'b1, 4);
    ctl.put(16'h0080, 32'sh000003e8);
  endtask

  task automatic t_abort;
    ctl.put(16'h00a4, 32'sh00001388);
    expect_obs("run no loop", 16, 1'b1, 4);
    check("loop off", obs(18), 1'b0);
    ctl.put(16'h0000, 32'sh00001388);
    expect_obs("release stop", 16, 1'b0, 3);
    expect_obs("aborted", 10, 1'b1, 4);
    check("pos error", obs(4), 1'b1);
    ctl.put(16'h0080, 32'sh00001388);
  endtask

  task automatic t_hwerr;
    ctl.put(16'h0084, 32'sh00002328);
    expect_obs("run again", 16, 1'b1, 4);
    expect_obs("pos err clr", 4, 1'b0, 3);
    @(posedge clk) sense.int_err <= 1'b1;
    expect_obs("hw error", 11, 1'b1, 4);
    expect_obs("error stop", 16, 1'b0, 3);
    @(posedge clk) sense.int_err <= 1'b0;
    settle(3);
    check("start blocked", obs(16), 1'b0);
    ctl.put(16'h0000, tgt);
    ctl.put(16'h0080, tgt);
    expect_obs("hw error clr", 11, 1'b0, 4);
    check("err memory", last_err[ST_HW_ERR], 1'b1);
  endtask

  task automatic t_save;
    confirm_fall();
    settle(4);
    @(posedge clk) save_cmd <= 1'b1;
    @(posedge clk) save_cmd <= 1'b0;
    expect_obs("explicit save", 17, 1'b1, 6);
    @(posedge clk) cfg.fw_new <= 1'b1;
    confirm_fall();
    expect_obs("auto save", 17, 1'b1, 8);
  endtask

  task automatic t_supply;
    @(posedge clk) sense.supply_dv <= 16'h0096;
    expect_obs("low supply", 2, 1'b1, 4);
    expect_obs("supply bad", 13, 1'b0, 4);
    ctl.put(16'h0084, 32'sh00004e20);
    settle(3);
    check("no start low", obs(16), 1'b0);
    ctl.put(16'h0080, tgt);
    @(posedge clk) sense.supply_dv <= 16'h00f0;
    expect_obs("supply ok", 13, 1'b1, 4);
    check("low sticky", obs(2), 1'b1);
    confirm_fall();
    expect_obs("low cleared", 2, 1'b0, 4);
    check("low in memory", last_err[ST_NO_SUPPLY], 1'b1);
  endtask

  task automatic t_temp;
    @(posedge clk) sense.temp_c <= 16'h005a;
    expect_obs("overtemp", 7, 1'b1, 4);
    ctl.put(16'h0084, 32'sh00004e20);
    settle(3);
    check("no start hot", obs(16), 1'b0);
    ctl.put(16'h0080, tgt);
    @(posedge clk) sense.temp_c <= 16'h0019;
    settle(3);
    check("hot sticky", obs(7), 1'b1);
    confirm_fall();
    expect_obs("hot cleared", 7, 1'b0, 4);
  endtask

  task automatic t_ref;
    @(posedge clk) sense.act_pos <= 32'sh000001f4;
    ctl.pulse(16'h0010, 32'sh000000c8);
    settle(3);
    check("ref value", ref_offset, 32'h0000012c);
    ctl.pulse(16'h0030, 32'sh00000000);
    settle(3);
    check("ref refused", ref_offset, 32'h0000012c);
    ctl.pulse(16'h0008, 32'sh000003e8);
    settle(3);
    check("zero new fw", ref_offset, 32'hfffffe0c);
    @(posedge clk) cfg.fw_new <= 1'b0;
    ctl.pulse(16'h0008, 32'sh00000000);
    settle(3);
    check("zero old fw", ref_offset, 32'h000001f4);
  endtask

  task automatic t_jog;
    @(posedge clk) jog_down_pin <= 1'b1;
    expect_obs("jog down", 9, 1'b1, 6);
    check("jog up idle", obs(8), 1'b0);
    @(posedge clk) {jog_down_pin, jog_up_pin} <= 2'b01;
    expect_obs("jog up", 8, 1'b1, 6);
    check("jog down idle", obs(9), 1'b0);
    ctl.put(16'h00c0, tgt);
    expect_obs("jog drives", 16, 1'b1, 6);
    check("jog dir", obs(19), 1'b1);
    expect_obs("manual speed", 20, 1'b1, 12);
    @(posedge clk) sense.act_pos <= 32'sh001e8480;
    expect_obs("limit stop", 16, 1'b0, 3);
    @(posedge clk) jog_up_pin <= 1'b0;
    ctl.put(16'h0080, tgt);
  endtask

  task automatic t_range;
    @(posedge clk) sense.act_pos <= 32'sh001e8480;
    expect_obs("upper limit", 1, 1'b1, 4);
    check("lower idle", obs(0), 1'b0);
    @(posedge clk) sense.act_pos <= -32'sh001e8480;
    expect_obs("lower limit", 0, 1'b1, 4);
    expect_obs("upper clr", 1, 1'b0, 4);
    @(posedge clk) sense.act_pos <= 32'sh000001f4;
    expect_obs("lower clr", 0, 1'b0, 4);
  endtask

  task automatic t_misc;
    @(posedge clk) sense.bad_value <= 1'b1;
    expect_obs("invalid", 5, 1'b1, 4);
    @(posedge clk) sense.bad_value <= 1'b0;
    ctl.put(16'hfe00, 32'sh00004e20);
    settle(4);
    check("upper ignored", obs(16), 1'b0);
    ctl.put(16'hfe84, 32'sh00000000);
    expect_obs("upper kept run", 16, 1'b1, 4);
    ctl.put(16'h0080, tgt);
  endtask

  initial begin
    #(50 * 5000);
    n_errors++;
    final_report();
  end

  initial begin
    n_errors = 0;
    n_tests = 0;
    rst_n = 1'b0;
    save_cmd = 1'b0;
    jog_down_pin = 1'b0;
    jog_up_pin = 1'b0;
    cfg = '{min_supply_dv: 16'h00be, temp_limit: 16'h0046, pos_window: 16'h0004,
            drag_limit: 16'h0064, jog_pause_ms: 16'h0002, jog_step: 16'h000a,
            loop_enable: 1'b1, jog_param_en: 1'b0, fw_new: 1'b0,
            range_hi: 32'sh000186a0, range_lo: -32'sh000186a0};
    sense = '{int_err: 1'b0, bad_value: 1'b0, supply_dv: 16'h00f0,
              temp_c: 16'h0019, act_pos: 32'sh00000000};
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("status in reset", status, 16'h0000);
    @(posedge clk) rst_n <= 1'b1;
    ctl.put(16'h0080, 32'sh00000000);
    settle(3);
    t_run();
    t_abort();
    t_hwerr();
    t_save();
    t_supply();
    t_temp();
    t_ref();
    t_jog();
    t_range();
    t_misc();
    final_report();
  end
endmodule // pcw_core_bench
`default_nettype wire
